//--- bench/servo_param_write_and_io_diag_tb.sv
`timescale 1ns/1ps
module servo_param_write_and_io_diag_tb;
  import svpio_pkg::*;
  // ==========================================================
  // clock, stimulus and observed signals
  logic clock = 0, nrst = 0, req_valid = 0, req_hex = 0;
  logic es_pin = 0, fwd_pin = 0, rev_pin = 0, pulse_pin = 0;
  logic [8:0] din_pins = 0;
  logic [11:0] analog_in = 0;
  logic [6:0] dout_req = 0, dout_pins, sig;
  logic [5:0] param_sel = 0, req_param = 0;
  logic [3:0] req_dp = 0;
  logic [23:0] req_value = 0;
  logic [31:0] req_force = 0, rdata, param_q, r = 32'h075F;
  svpio_kind_t req_kind = K_READ_IN;
  logic req_ready, done, done_ok, refused, in_dis_seen, in_disabled, out_disabled;
  logic pulse_eff, es_in;
  logic [11:0] analog_eff;
  int err_total = 0, checked = 0, m_param [50], p;
  always #12.5 clock = ~clock;

  svpio_link_if svpio_link_if_inst ();
  svpio_dev svpio_dev_inst (.clock(clock), .nrst(nrst), .link(svpio_link_if_inst),
    .din_pins(din_pins), .emergency_stop_pin(es_pin), .fwd_limit_pin(fwd_pin),
    .rev_limit_pin(rev_pin), .pulse_pin(pulse_pin), .analog_in(analog_in),
    .dout_req(dout_req), .param_sel(param_sel), .servo_enable_input(sig[0]),
    .forward_stroke_limit(sig[1]), .reverse_stroke_limit(sig[2]),
    .torque_limit_select(sig[3]), .proportional_control(sig[4]),
    .fault_clear_input(sig[5]), .error_clear_input(sig[6]), .emergency_stop_input(es_in),
    .analog_eff(analog_eff), .pulse_eff(pulse_eff), .dout_pins(dout_pins),
    .in_disabled(in_disabled), .out_disabled(out_disabled), .param_q(param_q));
  svpio_mst svpio_mst_inst (.clock(clock), .nrst(nrst), .link(svpio_link_if_inst),
    .req_valid(req_valid), .req_kind(req_kind), .req_param(req_param), .req_hex(req_hex),
    .req_dp(req_dp), .req_value(req_value), .req_force(req_force), .req_ready(req_ready),
    .done(done), .done_ok(done_ok), .refused(refused), .rdata(rdata),
    .in_dis_seen(in_dis_seen));
  svpio_checker svpio_checker_inst (.clock(clock), .nrst(nrst),
    .m_char(svpio_link_if_inst.m_char), .m_valid(svpio_link_if_inst.m_valid),
    .m_last(svpio_link_if_inst.m_last), .s_char(svpio_link_if_inst.s_char),
    .s_valid(svpio_link_if_inst.s_valid), .s_last(svpio_link_if_inst.s_last));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d, comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one request, held for one clock edge, then a bounded wait for done
  task automatic run(input svpio_kind_t k, input logic [5:0] pn, input logic [3:0] dp,
                     input logic [23:0] v, input logic [31:0] f, input logic ok);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_kind  <= k;
    req_param <= pn;
    req_dp    <= dp;
    req_value <= v;
    req_force <= f;
    @(posedge clock);
    req_valid <= 1'b0;
    // a local refusal pulses done on the take edge itself
    #1;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 200) err_total++;
    chk(done_ok, ok);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      din_pins  <= r[8:0];
      dout_req  <= r[15:9];
      analog_in <= r[27:16];
      settle(4);
      run(K_READ_IN, 6'h0, 4'h0, 24'h0, 32'h0, 1'b1);
      chk(rdata, {23'h0, r[8:0]});
      run(K_READ_OUT, 6'h0, 4'h0, 24'h0, 32'h0, 1'b1);
      chk(rdata, {25'h0, r[15:9]});
      p = (i == 0) ? 49 : int'(r[5:0]) % 50;
      m_param[p] = int'(r[30:8] & 23'h7FFFFF);
      run(K_PARAM_WR, 6'(p), 4'h2, 24'(m_param[p]), 32'h0, 1'b1);
      param_sel <= 6'(p);
      settle(2);
      chk(param_q[23:0], 24'(m_param[p]));
      run(K_PARAM_WR, 6'(p), 4'h0, ~24'(m_param[p]) & 24'h7FFFFF, 32'h0, 1'b0);
      chk({refused, param_q[23:0]}, {1'b1, 24'(m_param[p])});
    end
    // hex-handled write goes out with point 0, which a decimal parameter refuses
    req_hex <= 1'b1;
    run(K_PARAM_WR, 6'(p), 4'h3, 24'h00ABCD, 32'h0, 1'b0);
    chk({refused, param_q[23:0]}, {1'b0, 24'(m_param[p])});
    req_hex <= 1'b0;
    run(K_FORCE_IN, 6'h0, 4'h0, 24'h0, 32'h0000_00EF, 1'b0);
    chk(refused, 1'b1);
    din_pins  <= 9'h1FF;
    pulse_pin <= 1'b1;
    analog_in <= 12'hABC;
    run(K_IN_DIS, 6'h0, 4'h0, 24'h0, 32'h0, 1'b1);
    es_pin  <= 1'b1;
    fwd_pin <= 1'b1;
    rev_pin <= 1'b1;
    settle(4);
    chk({in_disabled, in_dis_seen, req_ready, sig}, {3'b111, 7'h06});
    chk({analog_eff, pulse_eff, es_in}, {12'h0, 2'b01});
    run(K_FORCE_IN, 6'h0, 4'h0, 24'h0, 32'hFFFF_FF10, 1'b1);
    settle(2);
    chk(sig, 7'h06);
    run(K_FORCE_IN, 6'h0, 4'h0, 24'h0, 32'h0000_00EF, 1'b1);
    settle(2);
    chk(sig, 7'h7F);
    run(K_IN_EN, 6'h0, 4'h0, 24'h0, 32'h0, 1'b1);
    settle(2);
    chk({in_disabled, analog_eff, pulse_eff}, {1'b0, 12'hABC, 1'b1});
    run(K_OUT_DIS, 6'h0, 4'h0, 24'h0, 32'h0, 1'b1);
    settle(2);
    chk({out_disabled, dout_pins}, {1'b1, 7'h0});
    run(K_OUT_EN, 6'h0, 4'h0, 24'h0, 32'h0, 1'b1);
    settle(2);
    chk({out_disabled, dout_pins}, {1'b0, r[15:9]});
    finish_test();
  end
endmodule

//--- bench/svpio_checker.sv
`timescale 1ns/1ps
// ==========================================================
// link checks between the two ends
module svpio_checker (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic [7:0] m_char,
  input wire logic       m_valid,
  input wire logic       m_last,
  input wire logic [7:0] s_char,
  input wire logic       s_valid,
  input wire logic       s_last
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // ascii 0-9 or A-F only; lower case would be a framing slip
  function automatic logic hx(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction

  // exec edge, then the registered tx flag: first reply char is sampled three edges on
  property p_ans;   m_valid && m_last |-> ##3 $rose(s_valid); endproperty
  property p_cause; $rose(s_valid) |-> $past(m_last, 3); endproperty
  property p_rhex;  s_valid && !s_last |-> hx(s_char); endproperty
  property p_ack;   $rose(s_valid) && s_last |-> s_char == 8'h06 || s_char == 8'h15; endproperty
  property p_len;
    $rose(s_valid) && !s_last |-> (s_valid && !s_last)[*7] ##1 (s_valid && s_last);
  endproperty
  property p_end;   s_valid && s_last |=> !s_valid; endproperty
  property p_half;  s_valid |-> !m_valid; endproperty
  property p_mhex;  m_valid |-> hx(m_char); endproperty

  a_ans: assert property (p_ans) else $error("reply late or missing");
  a_cause: assert property (p_cause) else $error("reply without frame");
  a_rhex: assert property (p_rhex) else $error("reply char not hex");
  a_ack: assert property (p_ack) else $error("short reply not ack or nak");
  a_len: assert property (p_len) else $error("bitmap reply not 8 chars");
  a_end: assert property (p_end) else $error("reply runs past last");
  a_half: assert property (p_half) else $error("frame during reply");
  a_mhex: assert property (p_mhex) else $error("frame char not hex");

  c_ack: cover property (s_valid && s_last && s_char == 8'h06);
  c_data: cover property ($rose(s_valid) && !s_last);
  c_frame: cover property (m_valid && m_last);
endmodule

//--- verilog/svpio_dev.sv
`timescale 1ns/1ps
// How it works
// R01: command 84 writes set data into parameter
// R02: data number hex equals parameter number
// R03: decimal parameter without point position refused
// R04: hex-handled parameter sends point position zero
// R05: master caps writes per parameter at limit
// R06: master sends only values within range
// R07: master confirms the write outcome
// R08: command 12/40 returns input pin bitmap
// R09: input bits 0..8 follow pin on/off
// R10: bitmaps leave as hex characters
// R11: command 12/C0 returns output pin bitmap
// R12: output bits 0..6, one means on
// R13: input group disable ignores pin levels
// R14: disabled inputs read off, 0V, no pulses
// R15: stop and stroke limits always follow pins; forced word bits 1 and 2 also set the stroke limits
// R16: command 90 key disables/enables input group
// R17: command 90 key disables/enables output group
// R18: command 92/00 word drives internal inputs
// R19: master forces inputs only after disabling inputs
// R20: forced word bit layout, bit 4 unused
// R21: every frame answers ack or data; a refused or unknown frame gets nak instead
// R22: point position n marks n-th digit
// R23: unassigned bitmap bits read zero, ignored
// R24: wrong key leaves group states unchanged
module svpio_dev
  import svpio_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               nrst,
  svpio_link_if.dev               link,
  input  wire logic [8:0]         din_pins,
  input  wire logic               emergency_stop_pin,
  input  wire logic               fwd_limit_pin,
  input  wire logic               rev_limit_pin,
  input  wire logic               pulse_pin,
  input  wire logic [11:0]        analog_in,
  input  wire logic [6:0]         dout_req,
  input  wire logic [5:0]         param_sel,
  output logic                    servo_enable_input,
  output logic                    forward_stroke_limit,
  output logic                    reverse_stroke_limit,
  output logic                    torque_limit_select,
  output logic                    proportional_control,
  output logic                    fault_clear_input,
  output logic                    error_clear_input,
  output logic                    emergency_stop_input,
  output logic [11:0]             analog_eff,
  output logic                    pulse_eff,
  output logic [6:0]              dout_pins,
  output logic                    in_disabled,
  output logic                    out_disabled,
  output logic [31:0]             param_q
);
  import svpio_pkg::*;

  typedef enum logic [1:0] {
    ST_RX   = 2'b00,
    ST_EXEC = 2'b01,
    ST_TX   = 2'b10
  } svpio_dst_t;

  svpio_dst_t                     st_r;
  logic       [NUM_SYNC-1:0]      pins_s;
  logic       [8:0]               din_s;
  logic       [15:0]              hdr_r;
  logic       [31:0]              data_r;
  logic       [3:0]               cnt_r;
  logic       [3:0]               dlen_r;
  logic                           bad_r;
  logic       [4:0]               dec;
  logic       [31:0]              force_r;
  logic       [31:0]              param_r [NUM_PARAMS];
  logic       [31:0]              tx_word_r;
  logic       [3:0]               tx_left_r;
  logic                           tx_data_r;
  logic                           tx_ok_r;
  logic       [7:0]               cmd;
  logic       [7:0]               dnum;
  logic                           key_ok;
  logic                           pw_ok;

  // ==========================================================
  // pin synchronisers
  svpio_sync #(.W(NUM_SYNC)) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .d     ({pulse_pin, rev_limit_pin, fwd_limit_pin, emergency_stop_pin, din_pins}),
    .q     (pins_s)
  );
  assign din_s = pins_s[8:0];

  // ==========================================================
  // frame reception and decode
  assign dec    = hex_to_nib(link.m_char);
  assign cmd    = hdr_r[15:8];
  assign dnum   = hdr_r[7:0];
  // the key must be the whole four-character data field
  assign key_ok = !bad_r && dlen_r == LEN_KEY && data_r[15:0] == IO_KEY; // [R24]
  // decimal parameters need a point position, hex ones do not
  assign pw_ok  = !bad_r && dlen_r == LEN_WORD && dnum <= DN_PARAM_LAST
                  && data_r[DP_MSB -: 4] <= DP_MAX
                  && (HEX_PARAMS[dnum[5:0]] || data_r[DP_MSB -: 4] != 4'h0); // [R03] [R22]

  // state sequencing: receive, execute one cycle, transmit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_RX;
    end else begin
      case (st_r)
        ST_RX:   st_r <= (link.m_valid && link.m_last) ? ST_EXEC : ST_RX;
        ST_EXEC: st_r <= ST_TX;
        ST_TX:   st_r <= (tx_left_r == 4'h1) ? ST_RX : ST_TX;
        default: st_r <= ST_RX;
      endcase
    end
  end

  // header nibbles first, then data nibbles msb first
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hdr_r  <= 16'h0000;
      data_r <= 32'h0000_0000;
      cnt_r  <= 4'h0;
      dlen_r <= 4'h0;
      bad_r  <= 1'b0;
    end else if (st_r == ST_RX && link.m_valid) begin
      if (cnt_r < HDR_CHARS) begin
        hdr_r <= {hdr_r[11:0], dec[3:0]}; // [R02]
      end else begin
        data_r <= {data_r[27:0], dec[3:0]};
        dlen_r <= (dlen_r < FRAME_MAX) ? dlen_r + 4'h1 : dlen_r;
      end
      // bad character or overlong frame poisons the frame
      bad_r <= bad_r | !dec[4] | (cnt_r == FRAME_MAX);
      cnt_r <= link.m_last ? 4'h0 : ((cnt_r < FRAME_MAX) ? cnt_r + 4'h1 : cnt_r);
    end else if (st_r == ST_TX) begin
      dlen_r <= 4'h0;
      bad_r  <= 1'b0;
    end
  end

  // ==========================================================
  // command execution: group gates and forced inputs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      in_disabled  <= 1'b0;
      out_disabled <= 1'b0;
    end else if (st_r == ST_EXEC && cmd == CMD_IO_GATE && key_ok) begin
      case (dnum)
        DN_IN_DIS:  in_disabled  <= 1'b1; // [R13] [R16]
        DN_IN_EN:   in_disabled  <= 1'b0; // [R16]
        DN_OUT_DIS: out_disabled <= 1'b1; // [R17]
        DN_OUT_EN:  out_disabled <= 1'b0; // [R17]
        default:    in_disabled  <= in_disabled;
      endcase
    end
  end

  // only the defined signal bits are kept
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      force_r <= FORCE_RST;
    end else if (st_r == ST_EXEC && cmd == CMD_FORCE_IN && dnum == DN_FORCE_IN
                 && !bad_r && dlen_r == LEN_WORD) begin
      force_r <= {24'h000000, data_r[7:0] & FORCE_MASK}; // [R18] [R20] [R23]
    end
  end

  // parameter store; reset clears it, no retention model here
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_PARAMS; i++) begin
        param_r[i] <= 32'h0000_0000;
      end
    end else if (st_r == ST_EXEC && cmd == CMD_PARAM_WR && pw_ok) begin
      param_r[dnum[5:0]] <= data_r; // [R01]
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      param_q <= 32'h0000_0000;
    end else begin
      param_q <= (param_sel < 6'(NUM_PARAMS)) ? param_r[param_sel] : 32'h0000_0000;
    end
  end

  // ==========================================================
  // reply: one ack/nak char, or eight hex chars of a bitmap
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_word_r <= 32'h0000_0000;
      tx_left_r <= 4'h0;
      tx_data_r <= 1'b0;
      tx_ok_r   <= 1'b0;
    end else if (st_r == ST_EXEC) begin
      tx_data_r <= 1'b0;
      tx_left_r <= 4'h1;
      tx_word_r <= 32'h0000_0000;
      case (cmd)
        CMD_PARAM_WR: tx_ok_r <= pw_ok; // [R21]
        CMD_IO_GATE:  tx_ok_r <= key_ok && (dnum == DN_IN_DIS || dnum == DN_IN_EN
                                 || dnum == DN_OUT_DIS || dnum == DN_OUT_EN);
        CMD_FORCE_IN: tx_ok_r <= !bad_r && dlen_r == LEN_WORD && dnum == DN_FORCE_IN;
        CMD_DIAG: begin
          tx_ok_r <= 1'b0;
          if (!bad_r && dnum == DN_IN_STAT) begin
            tx_data_r <= 1'b1;
            tx_left_r <= LEN_WORD;
            tx_word_r <= {23'h000000, din_s}; // [R08] [R09] [R23]
          end else if (!bad_r && dnum == DN_OUT_STAT) begin
            tx_data_r <= 1'b1;
            tx_left_r <= LEN_WORD;
            tx_word_r <= {25'h0000000, dout_pins}; // [R11] [R12] [R23]
          end
        end
        default: tx_ok_r <= 1'b0;
      endcase
    end else if (st_r == ST_TX) begin
      tx_word_r <= {tx_word_r[27:0], 4'h0};
      tx_left_r <= tx_left_r - 4'h1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      link.s_char  <= 8'h00;
      link.s_valid <= 1'b0;
      link.s_last  <= 1'b0;
    end else begin
      link.s_valid <= (st_r == ST_TX);
      link.s_last  <= (st_r == ST_TX) && (tx_left_r == 4'h1);
      if (st_r == ST_TX) begin
        link.s_char <= tx_data_r ? nib_to_hex(tx_word_r[31:28])
                                 : (tx_ok_r ? CH_ACK : CH_NAK); // [R10] [R21]
      end
    end
  end

  // ==========================================================
  // effective signals seen by the servo logic
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      servo_enable_input   <= 1'b0;
      torque_limit_select  <= 1'b0;
      proportional_control <= 1'b0;
      fault_clear_input    <= 1'b0;
      error_clear_input    <= 1'b0;
      analog_eff           <= 12'h000;
      pulse_eff            <= 1'b0;
    end else begin
      servo_enable_input   <= (din_s[0] & ~in_disabled) | force_r[0]; // [R14] [R20]
      torque_limit_select  <= (din_s[3] & ~in_disabled) | force_r[3];
      proportional_control <= (din_s[5] & ~in_disabled) | force_r[5];
      fault_clear_input    <= (din_s[6] & ~in_disabled) | force_r[6];
      error_clear_input    <= (din_s[7] & ~in_disabled) | force_r[7];
      analog_eff           <= in_disabled ? 12'h000 : analog_in; // [R14]
      pulse_eff            <= pins_s[12] & ~in_disabled; // [R14]
    end
  end

  // safety inputs bypass the disable gate entirely
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      emergency_stop_input <= 1'b0;
      forward_stroke_limit <= 1'b0;
      reverse_stroke_limit <= 1'b0;
      dout_pins            <= 7'h00;
    end else begin
      emergency_stop_input <= pins_s[9]; // [R15]
      forward_stroke_limit <= pins_s[10] | force_r[FRC_FWD_LIM]; // [R15]
      reverse_stroke_limit <= pins_s[11] | force_r[FRC_REV_LIM]; // [R15]
      dout_pins            <= out_disabled ? 7'h00 : dout_req; // [R17]
    end
  end
endmodule

//--- verilog/svpio_link_if.sv
`timescale 1ns/1ps
// character link: master frames on m_*, device replies on s_*
interface svpio_link_if;
  logic [7:0] m_char;
  logic       m_valid;
  logic       m_last;
  logic [7:0] s_char;
  logic       s_valid;
  logic       s_last;

  modport dev (input m_char, input m_valid, input m_last,
               output s_char, output s_valid, output s_last);
  modport mst (output m_char, output m_valid, output m_last,
               input s_char, input s_valid, input s_last);
endinterface

//--- verilog/svpio_mst.sv
`timescale 1ns/1ps
// master station end: builds frames, collects replies
module svpio_mst
  import svpio_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               nrst,
  svpio_link_if.mst               link,
  input  wire logic               req_valid,
  input  wire svpio_pkg::svpio_kind_t req_kind,
  input  wire logic [5:0]         req_param,
  input  wire logic               req_hex,
  input  wire logic [3:0]         req_dp,
  input  wire logic [23:0]        req_value,
  input  wire logic [31:0]        req_force,
  output logic                    req_ready,
  output logic                    done,
  output logic                    done_ok,
  output logic                    refused,
  output logic [31:0]             rdata,
  output logic                    in_dis_seen
);
  import svpio_pkg::*;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_SEND = 2'b01,
    M_WAIT = 2'b10
  } svpio_mst_t;

  svpio_mst_t                     st_r;
  svpio_kind_t                    kind_r;
  logic       [7:0]               ch_r [12];
  logic       [3:0]               len_r;
  logic       [3:0]               idx_r;
  logic       [16:0]              wr_cnt_r [NUM_PARAMS];
  logic       [5:0]               prm_r;
  logic       [31:0]              word;
  logic       [15:0]              hdr;
  logic       [3:0]               dlen;
  logic                           local_no;
  logic       [4:0]               rnib;

  // ==========================================================
  // frame composition
  always_comb begin
    word = {4'h0, (req_hex ? 4'h0 : req_dp), req_value}; // [R04]
    hdr  = {CMD_PARAM_WR, 2'b00, req_param};
    dlen = LEN_WORD;
    case (req_kind)
      K_PARAM_WR: hdr = {CMD_PARAM_WR, 2'b00, req_param}; // [R01] [R02]
      K_READ_IN:  begin hdr = {CMD_DIAG, DN_IN_STAT};  dlen = 4'h0; end // [R08]
      K_READ_OUT: begin hdr = {CMD_DIAG, DN_OUT_STAT}; dlen = 4'h0; end // [R11]
      K_IN_DIS:   begin hdr = {CMD_IO_GATE, DN_IN_DIS};  dlen = LEN_KEY; end // [R16]
      K_IN_EN:    begin hdr = {CMD_IO_GATE, DN_IN_EN};   dlen = LEN_KEY; end
      K_OUT_DIS:  begin hdr = {CMD_IO_GATE, DN_OUT_DIS}; dlen = LEN_KEY; end // [R17]
      K_OUT_EN:   begin hdr = {CMD_IO_GATE, DN_OUT_EN};  dlen = LEN_KEY; end
      K_FORCE_IN: begin hdr = {CMD_FORCE_IN, DN_FORCE_IN}; word = req_force; end // [R18]
      default:    dlen = 4'h0;
    endcase
    if (dlen == LEN_KEY) begin
      word = {16'h0000, IO_KEY};
    end
  end

  // refusals made here without touching the link
  assign local_no = (req_kind == K_PARAM_WR)
                    && (req_param >= 6'(NUM_PARAMS)
                        || wr_cnt_r[req_param] >= WR_LIMIT // [R05]
                        || req_value > PARAM_VAL_MAX // [R06]
                        || (!req_hex && (req_dp == 4'h0 || req_dp > DP_MAX)))
                    || (req_kind == K_FORCE_IN && !in_dis_seen); // [R19]

  // reply char back to its nibble; a function result cannot be part-selected
  assign rnib = hex_to_nib(link.s_char);

  // ==========================================================
  // sequencing, character send and reply collection
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r      <= M_IDLE;
      kind_r    <= K_PARAM_WR;
      len_r     <= 4'h0;
      idx_r     <= 4'h0;
      prm_r     <= 6'h00;
      req_ready <= 1'b1;
      done      <= 1'b0;
      done_ok   <= 1'b0;
      refused   <= 1'b0;
      rdata     <= 32'h0000_0000;
      for (int i = 0; i < 12; i++) begin
        ch_r[i] <= 8'h00;
      end
    end else begin
      done <= 1'b0;
      case (st_r)
        M_IDLE: if (req_valid) begin
          kind_r  <= req_kind;
          prm_r   <= req_param;
          refused <= local_no;
          if (local_no) begin
            done    <= 1'b1;
            done_ok <= 1'b0;
          end else begin
            for (int i = 0; i < 4; i++) begin
              ch_r[i] <= nib_to_hex(hdr[15 - 4*i -: 4]);
            end
            for (int i = 0; i < 8; i++) begin
              ch_r[4 + i] <= nib_to_hex((dlen == LEN_KEY) ? word[15 - 4*(i%4) -: 4]
                                                          : word[31 - 4*i -: 4]);
            end
            len_r     <= HDR_CHARS + dlen;
            idx_r     <= 4'h0;
            req_ready <= 1'b0;
            st_r      <= M_SEND;
          end
        end
        M_SEND: begin
          idx_r <= idx_r + 4'h1;
          if (idx_r == len_r - 4'h1) begin
            idx_r <= 4'h0;
            rdata <= 32'h0000_0000;
            st_r  <= M_WAIT;
          end
        end
        M_WAIT: if (link.s_valid) begin
          rdata <= {rdata[27:0], rnib[3:0]}; // [R10]
          if (link.s_last) begin
            done      <= 1'b1;
            done_ok   <= (link.s_char != CH_NAK); // [R07]
            req_ready <= 1'b1;
            st_r      <= M_IDLE;
          end
        end
        default: st_r <= M_IDLE;
      endcase
    end
  end

  // link pins registered from the frame buffer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      link.m_char  <= 8'h00;
      link.m_valid <= 1'b0;
      link.m_last  <= 1'b0;
    end else begin
      link.m_valid <= (st_r == M_SEND);
      link.m_last  <= (st_r == M_SEND) && (idx_r == len_r - 4'h1);
      link.m_char  <= ch_r[idx_r];
    end
  end

  // per-parameter write tally, counted only on acknowledged writes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_PARAMS; i++) begin
        wr_cnt_r[i] <= 17'h00000;
      end
      in_dis_seen <= 1'b0;
    end else if (st_r == M_WAIT && link.s_valid && link.s_last && link.s_char == CH_ACK) begin
      if (kind_r == K_PARAM_WR) begin
        wr_cnt_r[prm_r] <= wr_cnt_r[prm_r] + 17'h00001; // [R05]
      end else if (kind_r == K_IN_DIS) begin
        in_dis_seen <= 1'b1; // [R19]
      end else if (kind_r == K_IN_EN) begin
        in_dis_seen <= 1'b0;
      end
    end
  end
endmodule

//--- verilog/svpio_pkg.sv
package svpio_pkg;

  // ==========================================================
  // command codes and data numbers
  localparam logic [7:0]  CMD_PARAM_WR  = 8'h84;
  localparam logic [7:0]  CMD_DIAG      = 8'h12;
  localparam logic [7:0]  CMD_IO_GATE   = 8'h90;
  localparam logic [7:0]  CMD_FORCE_IN  = 8'h92;
  localparam logic [7:0]  DN_IN_STAT    = 8'h40;
  localparam logic [7:0]  DN_OUT_STAT   = 8'hC0;
  localparam logic [7:0]  DN_IN_DIS     = 8'h00;
  localparam logic [7:0]  DN_OUT_DIS    = 8'h03;
  localparam logic [7:0]  DN_IN_EN      = 8'h10;
  localparam logic [7:0]  DN_OUT_EN     = 8'h13;
  localparam logic [7:0]  DN_FORCE_IN   = 8'h00;
  localparam logic [7:0]  DN_PARAM_LAST = 8'h31;
  localparam logic [15:0] IO_KEY        = 16'h1EA5;

  // ==========================================================
  // frame and reply characters
  localparam logic [7:0]  CH_ACK        = 8'h06;
  localparam logic [7:0]  CH_NAK        = 8'h15;
  localparam logic [3:0]  HDR_CHARS     = 4'h4;
  localparam logic [3:0]  LEN_KEY       = 4'h4;
  localparam logic [3:0]  LEN_WORD      = 4'h8;
  localparam logic [3:0]  FRAME_MAX     = 4'hC;

  // ==========================================================
  // parameters, pins and bitmap layout
  localparam int          NUM_PARAMS    = 50;
  localparam int          NUM_DIN       = 9;
  localparam int          NUM_DOUT      = 7;
  localparam int          NUM_SYNC      = 13;
  localparam logic [3:0]  DP_MAX        = 4'h5;
  localparam int          DP_MSB        = 27;
  localparam logic [49:0] HEX_PARAMS    = 50'h0;
  localparam logic [23:0] PARAM_VAL_MAX = 24'h7FFFFF;
  localparam logic [16:0] WR_LIMIT      = 17'h186A0;
  localparam logic [31:0] FORCE_RST     = 32'h0000_0000;
  localparam logic [7:0]  FORCE_MASK    = 8'hEF;
  localparam int          FRC_FWD_LIM   = 1;
  localparam int          FRC_REV_LIM   = 2;

  typedef enum logic [2:0] {
    K_PARAM_WR = 3'h0,
    K_READ_IN  = 3'h1,
    K_READ_OUT = 3'h2,
    K_IN_DIS   = 3'h3,
    K_IN_EN    = 3'h4,
    K_OUT_DIS  = 3'h5,
    K_OUT_EN   = 3'h6,
    K_FORCE_IN = 3'h7
  } svpio_kind_t;

  // ascii hex character to {valid, nibble}
  function automatic logic [4:0] hex_to_nib(input logic [7:0] ch);
    if (ch >= 8'h30 && ch <= 8'h39) begin
      hex_to_nib = {1'b1, ch[3:0]};
    end else if (ch >= 8'h41 && ch <= 8'h46) begin
      hex_to_nib = {1'b1, ch[3:0] + 4'h9};
    end else begin
      hex_to_nib = 5'h00;
    end
  endfunction

  // nibble to upper-case ascii hex character
  function automatic logic [7:0] nib_to_hex(input logic [3:0] n);
    nib_to_hex = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
  endfunction

endpackage

//--- verilog/svpio_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module svpio_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
